// ### inc/spims_regs.vh
// register map, field positions, reset values and widths of the serial port
`ifndef SPIMS_REGS_VH
`define SPIMS_REGS_VH

// register indices; byte address is four times the index
`define SPIMS_IDX_CTL1 6'h00
`define SPIMS_IDX_CTL2 6'h01
`define SPIMS_IDX_BAUD 6'h02
`define SPIMS_IDX_STAT 6'h03
`define SPIMS_IDX_DATA 6'h05

// port_control_one fields
`define SPIMS_C1_SPE 6
`define SPIMS_C1_MASTER_SELECT_BIT 4
`define SPIMS_C1_CPOL 3
`define SPIMS_C1_CPHA 2
`define SPIMS_C1_SSOE 1
`define SPIMS_C1_MASK 8'h5e
`define SPIMS_C1_RESET 8'h04

// port_control_two fields
`define SPIMS_C2_MASTER_CONFLICT_DETECT_ENABLE 4
`define SPIMS_C2_SINGLE_PIN_OUTPUT_ENABLE 3
`define SPIMS_C2_HALTW 1
`define SPIMS_C2_BIDIR 0
`define SPIMS_C2_MASK 8'h1b
`define SPIMS_C2_RESET 8'h00

// baud_divider_select fields
`define SPIMS_BR_PRE_HI 6
`define SPIMS_BR_PRE_LO 4
`define SPIMS_BR_SEL_HI 2
`define SPIMS_BR_SEL_LO 0
`define SPIMS_BR_MASK 8'h77
`define SPIMS_BR_RESET 8'h00

// port_status_register fields
`define SPIMS_ST_RECEIVE_FULL_FLAG 7
`define SPIMS_ST_TRANSMIT_EMPTY_FLAG 5
`define SPIMS_ST_MASTER_CONFLICT_FLAG 4

// transfer geometry
`define SPIMS_LAST_EDGE 4'hf
`define SPIMS_FIRST_EDGE 4'h0
`define SPIMS_DIV_W 11
`define SPIMS_BYTE_ZERO 8'h00

`endif

// ### hw/spims_port.v
// serial peripheral port: wishbone registers, baud divider, master/slave shifter
// Function
// - in master mode a change of either baud field aborts the transfer
// - master serial clock equals bus clock over the selected divisor
// - preselect zero gives divisors 2..256; preselect one doubles each
// - reserved baud bits ignore writes; register accessible anytime
// - while enabled the port owns its four pins
// - single-pin mode: enable sets direction, driven pin also feeds shifter
// - clock out as master, in as slave; select input as slave always
// - single-pin master with fault detect drops to slave on low select input
// - master with fault detect sets fault flag on low select input
// - master without fault detect ignores select, keeps fault flag clear
// - slave in wait/stop keeps shifting; flag and copy deferred to exit
// - slave keeps a pending received byte when entering wait or stop
// - slave idle through wait raises no flag and makes no copy
// - stopped master freezes mid-transfer and resumes; slave stays in step
// - stop behaviour ignores the halt-in-wait bit
// - slave without a data write may shift out stale content
// - data register reads zero after reset until a byte arrives
// - interrupt only while enabled, OR of fault, receive and transmit flags
// - fault flag set aborts transfer and clears master select
// - fault request stays while its flag is set; software clears it
//
// Local design decision: the Wishbone register port.
`include "spims_regs.vh"

module spims_port (
    input wire clk_i,              // bus clock, 100 MHz
    input wire rst_i,              // synchronous reset, active high
    input wire wb_cyc_i,           // wishbone cycle
    input wire wb_stb_i,           // wishbone strobe
    input wire wb_we_i,            // wishbone write
    input wire [7:0] wb_adr_i,     // byte address
    input wire [3:0] wb_sel_i,     // byte enables, lane 0 used
    input wire [31:0] wb_dat_i,    // write data
    output reg [31:0] wb_dat_o,    // read data
    output reg wb_ack_o,           // acknowledge
    input wire wait_i,             // system wait mode
    input wire stop_i,             // system stop mode, module clock held
    output wire irq_o,             // interrupt request, level
    input wire ss_i,               // slave select pin in
    output wire ss_o,              // slave select pin out
    output wire ss_oe_o,           // slave select drive enable
    input wire sck_i,              // serial clock pin in
    output wire sck_o,             // serial clock pin out
    output wire sck_oe_o,          // serial clock drive enable
    input wire mosi_i,             // master-out pin in
    output wire mosi_o,            // master-out pin out
    output wire mosi_oe_o,         // master-out drive enable
    input wire miso_i,             // master-in pin in
    output wire miso_o,            // master-in pin out
    output wire miso_oe_o          // master-in drive enable
);

    // registers
    reg [7:0] port_control_one;
    reg [7:0] port_control_two;
    reg [7:0] baud_divider_select;
    reg [7:0] tx_data;
    reg tx_full;
    reg [7:0] shift_data_register;
    reg receive_full_flag;
    reg master_conflict_flag;
    reg [7:0] shreg;
    reg in_bit;
    reg busy;
    reg [3:0] edge_cnt;
    reg [`SPIMS_DIV_W-1:0] div_cnt;
    reg sck_phase;
    reg sck_prev;
    reg lp_prev;
    reg deferred_valid;
    reg [7:0] deferred_byte;
    reg [3:0] pin_meta;
    reg [3:0] pin_sync;
    reg [1:0] late_smp;
    reg [1:0] late_end;
    reg [1:0] loop_d;
    reg [7:0] late_rx;

    // half of the divisor: (pre+1) << sel bus cycles per serial clock phase
    function [`SPIMS_DIV_W-1:0] half_period;
        input [2:0] pre;
        input [2:0] sel;
        begin
            half_period = {{(`SPIMS_DIV_W-4){1'b0}}, ({1'b0, pre} + 4'h1)} << sel;
        end
    endfunction

    // field views
    wire port_enable_bit = port_control_one[`SPIMS_C1_SPE];
    wire master_select_bit = port_control_one[`SPIMS_C1_MASTER_SELECT_BIT];
    wire cpol = port_control_one[`SPIMS_C1_CPOL];
    wire cpha = port_control_one[`SPIMS_C1_CPHA];
    wire ssoe = port_control_one[`SPIMS_C1_SSOE];
    wire master_conflict_detect_enable = port_control_two[`SPIMS_C2_MASTER_CONFLICT_DETECT_ENABLE];
    wire single_pin_output_enable = port_control_two[`SPIMS_C2_SINGLE_PIN_OUTPUT_ENABLE];
    wire halt_in_wait_bit = port_control_two[`SPIMS_C2_HALTW];
    wire single_pin_mode = port_control_two[`SPIMS_C2_BIDIR];
    wire [2:0] rate_preselect_field =
        baud_divider_select[`SPIMS_BR_PRE_HI:`SPIMS_BR_PRE_LO];
    wire [2:0] rate_select_field =
        baud_divider_select[`SPIMS_BR_SEL_HI:`SPIMS_BR_SEL_LO];
    wire transmit_empty_flag = ~tx_full;

    // synchronised pins: ss, sck, mosi, miso
    wire ss_s = pin_sync[3];
    wire sck_s = pin_sync[2];
    wire mosi_s = pin_sync[1];
    wire miso_s = pin_sync[0];

    // two-flop input synchronisers; only the second stage is read by logic
    always @(posedge clk_i) begin
        if (rst_i) begin
            pin_meta <= 4'hf;
            pin_sync <= 4'hf;
        end else begin
            pin_meta <= {ss_i, sck_i, mosi_i, miso_i};
            pin_sync <= pin_meta;
        end
    end

    // roles
    wire is_master = port_enable_bit & master_select_bit;
    wire is_slave = port_enable_bit & ~master_select_bit;
    // stop ignores the halt bit; wait only halts when asked
    wire low_power = stop_i | (wait_i & halt_in_wait_bit);
    wire slave_selected = is_slave & ~ss_s;

    // wishbone access completes at the edge where ack is high
    wire acc = wb_cyc_i & wb_stb_i & wb_ack_o;
    wire wr = acc & wb_we_i & wb_sel_i[0];
    wire rd = acc & ~wb_we_i;
    wire [5:0] idx = wb_adr_i[7:2];
    wire wr_ctl1 = wr & (idx == `SPIMS_IDX_CTL1);
    wire wr_ctl2 = wr & (idx == `SPIMS_IDX_CTL2);
    wire wr_baud = wr & (idx == `SPIMS_IDX_BAUD);
    wire wr_stat = wr & (idx == `SPIMS_IDX_STAT);
    wire wr_data = wr & (idx == `SPIMS_IDX_DATA);
    wire rd_data = rd & (idx == `SPIMS_IDX_DATA);
    wire [7:0] wbyte = wb_dat_i[7:0];

    // a baud write that actually changes a field aborts a master transfer
    wire baud_change = wr_baud &
        ((wbyte & `SPIMS_BR_MASK) != baud_divider_select);

    // fault: master, detect on, select used as input, pin pulled low
    wire fault = is_master & master_conflict_detect_enable & ~ssoe & ~ss_s;

    // incoming data bit per role and pin mode; a driven single pin loops back
    reg din;
    always @* begin
        din = 1'b0;
        if (master_select_bit) begin
            if (single_pin_mode)
                din = single_pin_output_enable ? loop_d[1] : mosi_s;
            else
                din = miso_s;
        end else begin
            if (single_pin_mode)
                din = single_pin_output_enable ? shreg[7] : miso_s;
            else
                din = mosi_s;
        end
    end

    // master baud tick: frozen while the module clock is held
    wire tick = is_master & busy & ~low_power & (div_cnt == {`SPIMS_DIV_W{1'b0}});
    // slave edge: any transition of the synchronised clock while selected
    wire slave_edge = slave_selected & (sck_s ^ sck_prev);
    wire xfer_edge = tick | slave_edge;
    wire sample_edge = (edge_cnt[0] == cpha);
    wire last_edge = (edge_cnt == `SPIMS_LAST_EDGE);
    wire byte_done = xfer_edge & last_edge;
    wire [7:0] done_byte = {shreg[6:0], cpha ? din : in_bit};
    wire abort = ~port_enable_bit | fault | (is_master & baud_change);

    // byte delivery: slave completion in low power is held back until exit
    // master data passes the pin flops too, so its samples land two cycles late;
    // sampling on the clock edge itself would read stale bits at the fastest rates
    wire [7:0] late_byte = late_smp[1] ? {late_rx[6:0], din} : late_rx;
    wire master_done = late_end[1];
    wire [7:0] rx_byte = master_done ? late_byte : done_byte;
    wire defer_now = byte_done & is_slave & low_power;
    wire deliver_now = master_done | (byte_done & is_slave & ~low_power);
    wire lp_exit = lp_prev & ~low_power;
    wire deliver_deferred = lp_exit & deferred_valid & ~deliver_now;
    wire rx_set = deliver_now | deliver_deferred;

    // control registers and fault flag
    always @(posedge clk_i) begin
        if (rst_i) begin
            port_control_one <= `SPIMS_C1_RESET;
            port_control_two <= `SPIMS_C2_RESET;
            baud_divider_select <= `SPIMS_BR_RESET;
            master_conflict_flag <= 1'b0;
        end else begin
            if (wr_ctl1)
                port_control_one <= wbyte & `SPIMS_C1_MASK;
            if (wr_ctl2)
                port_control_two <= wbyte & `SPIMS_C2_MASK;
            if (wr_baud)
                baud_divider_select <= wbyte & `SPIMS_BR_MASK;
            // fault drops master select, winning over a same-cycle write
            if (fault)
                port_control_one[`SPIMS_C1_MASTER_SELECT_BIT] <= 1'b0;
            // flag set wins over the write-one clear
            if (fault)
                master_conflict_flag <= 1'b1;
            else if (is_master & ~master_conflict_detect_enable)
                master_conflict_flag <= 1'b0;
            else if (wr_stat & wbyte[`SPIMS_ST_MASTER_CONFLICT_FLAG])
                master_conflict_flag <= 1'b0;
        end
    end

    // transfer engine
    always @(posedge clk_i) begin
        if (rst_i) begin
            busy <= 1'b0;
            edge_cnt <= `SPIMS_FIRST_EDGE;
            div_cnt <= {`SPIMS_DIV_W{1'b0}};
            sck_phase <= 1'b0;
            sck_prev <= 1'b0;
            shreg <= `SPIMS_BYTE_ZERO;
            in_bit <= 1'b0;
            tx_full <= 1'b0;
            tx_data <= `SPIMS_BYTE_ZERO;
        end else begin
            sck_prev <= sck_s;
            // software fills the transmit buffer only while it is empty
            if (wr_data & ~tx_full) begin
                tx_data <= wbyte;
                tx_full <= 1'b1;
            end
            if (abort) begin
                busy <= 1'b0;
                edge_cnt <= `SPIMS_FIRST_EDGE;
                sck_phase <= 1'b0;
            end else if (is_master) begin
                if (!busy) begin
                    sck_phase <= 1'b0;
                    // new master byte leaves the buffer, emptying it
                    if (tx_full & ~low_power) begin
                        busy <= 1'b1;
                        shreg <= tx_data;
                        tx_full <= 1'b0;
                        edge_cnt <= `SPIMS_FIRST_EDGE;
                        div_cnt <= half_period(rate_preselect_field,
                                               rate_select_field) - 1'b1;
                    end
                end else if (tick) begin
                    div_cnt <= half_period(rate_preselect_field,
                                           rate_select_field) - 1'b1;
                    sck_phase <= ~sck_phase;
                end else if (!low_power) begin
                    div_cnt <= div_cnt - 1'b1;
                end
            end else if (is_slave) begin
                busy <= slave_selected & (edge_cnt != `SPIMS_FIRST_EDGE);
                if (ss_s) begin
                    // deselected: restart bit count, preload any waiting byte
                    edge_cnt <= `SPIMS_FIRST_EDGE;
                    if (tx_full) begin
                        shreg <= tx_data;
                        tx_full <= 1'b0;
                    end
                end
            end
            // shared edge handling; master ends after the sixteenth edge
            if (xfer_edge & ~abort) begin
                edge_cnt <= edge_cnt + 1'b1;
                if (sample_edge) begin
                    in_bit <= din;
                    if (last_edge & is_slave) // a master output must not move with sck
                        shreg <= done_byte;
                end else if (!(cpha && edge_cnt == `SPIMS_FIRST_EDGE)) begin
                    shreg <= {shreg[6:0], in_bit};
                end
                if (last_edge & is_master)
                    busy <= 1'b0;
                // slave chains a buffered byte straight after the last edge
                if (last_edge & is_slave & tx_full & ~(wr_data & ~tx_full)) begin
                    shreg <= tx_data;
                    tx_full <= 1'b0;
                end
            end
        end
    end

    // late master sampling; an abort empties it so a cut byte never lands
    always @(posedge clk_i) begin
        if (rst_i) begin
            late_smp <= 2'h0;
            late_end <= 2'h0;
            loop_d <= 2'h0;
            late_rx <= `SPIMS_BYTE_ZERO;
        end else begin
            // looped bit delayed like a pin so single-pin mode lines up
            loop_d <= {loop_d[0], shreg[7]};
            if (late_smp[1])
                late_rx <= late_byte;
            if (abort) begin
                late_smp <= 2'h0;
                late_end <= 2'h0;
            end else begin
                late_smp <= {late_smp[0], tick & sample_edge};
                late_end <= {late_end[0], byte_done & is_master};
            end
        end
    end

    // receive path, deferral across wait/stop for the slave
    always @(posedge clk_i) begin
        if (rst_i) begin
            shift_data_register <= `SPIMS_BYTE_ZERO;
            receive_full_flag <= 1'b0;
            deferred_valid <= 1'b0;
            deferred_byte <= `SPIMS_BYTE_ZERO;
            lp_prev <= 1'b0;
        end else begin
            lp_prev <= low_power;
            if (deliver_now)
                shift_data_register <= rx_byte;
            else if (deliver_deferred)
                shift_data_register <= deferred_byte;
            // nothing deferred unless a byte finished in low power
            if (defer_now) begin
                deferred_valid <= 1'b1;
                deferred_byte <= rx_byte;
            end else if (low_power & ~lp_prev) begin
                deferred_valid <= 1'b0;
            end else if (lp_exit) begin
                deferred_valid <= 1'b0;
            end
            // new byte sets the flag even in the cycle a read clears it
            if (rx_set)
                receive_full_flag <= 1'b1;
            else if (rd_data)
                receive_full_flag <= 1'b0;
        end
    end

    // wishbone slave: ack one cycle after the request, dropped the next
    always @(posedge clk_i) begin
        if (rst_i)
            wb_ack_o <= 1'b0;
        else
            wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
    end

    // read data latched as ack rises; unmapped addresses read zero
    always @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (wb_cyc_i & wb_stb_i & ~wb_ack_o) begin
            if (idx == `SPIMS_IDX_CTL1)
                wb_dat_o <= {24'h00_0000, port_control_one};
            else if (idx == `SPIMS_IDX_CTL2)
                wb_dat_o <= {24'h00_0000, port_control_two};
            else if (idx == `SPIMS_IDX_BAUD)
                wb_dat_o <= {24'h00_0000, baud_divider_select};
            else if (idx == `SPIMS_IDX_STAT)
                wb_dat_o <= {24'h00_0000, receive_full_flag, 1'b0,
                             transmit_empty_flag, master_conflict_flag, 4'h0};
            else if (idx == `SPIMS_IDX_DATA)
                wb_dat_o <= {24'h00_0000, shift_data_register};
            else
                wb_dat_o <= 32'h0000_0000;
        end
    end

    // pin ownership while enabled; serial data always leaves from bit 7
    assign sck_o = cpol ^ sck_phase;
    assign sck_oe_o = is_master;
    // select drives low during a master byte when configured as output
    assign ss_o = ~busy;
    assign ss_oe_o = is_master & master_conflict_detect_enable & ssoe;
    assign mosi_o = shreg[7];
    assign miso_o = shreg[7];
    assign mosi_oe_o = is_master &
        (single_pin_mode ? single_pin_output_enable : 1'b1);
    assign miso_oe_o = slave_selected &
        (single_pin_mode ? single_pin_output_enable : 1'b1);

    // request only while enabled; fault part stays as long as its flag
    assign irq_o = port_enable_bit &
        (master_conflict_flag | receive_full_flag | transmit_empty_flag);

endmodule

// ### verification/spims_port_properties.sv
// bus, pin and fault checks on the serial port, bound to its top module
module spims_props (
    input wire clk_i, // bus clock
    input wire rst_i, // sync reset
    input wire wb_cyc_i, // cycle
    input wire wb_stb_i, // strobe
    input wire wb_we_i, // write
    input wire [7:0] wb_adr_i, // address
    input wire [3:0] wb_sel_i, // lanes
    input wire [31:0] wb_dat_i, // write data
    input wire [31:0] wb_dat_o, // read data
    input wire wb_ack_o, // ack
    input wire irq_o, // request
    input wire ss_i, // select in
    input wire ss_o, // select out
    input wire ss_oe_o, // select drive
    input wire sck_oe_o, // clock drive
    input wire mosi_oe_o, // mosi drive
    input wire miso_oe_o // miso drive
);
    timeunit 1ns;
    timeprecision 1ps;
    reg [7:0] br;
    reg master_conflict_flag_en;
    wire wr_ok = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_sel_i[0];
    // shadows follow writes at the ack edge, where the design applies them
    always @(posedge clk_i) begin
        if (rst_i) begin
            br <= 8'h00;
            master_conflict_flag_en <= 1'b0;
        end else if (wr_ok && wb_adr_i[7:2] == 6'h02) begin
            br <= wb_dat_i[7:0] & 8'h77;
        end else if (wr_ok && wb_adr_i[7:2] == 6'h01) begin
            master_conflict_flag_en <= wb_dat_i[4];
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence s_req; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
    sequence s_pulse; wb_ack_o ##1 !wb_ack_o; endsequence
    sequence s_lost; sck_oe_o && master_conflict_flag_en && !ss_oe_o && !ss_i; endsequence
    property p_ack_next; s_req |=> s_pulse; endproperty
    property p_ack_src; wb_ack_o |-> $past(wb_cyc_i && wb_stb_i); endproperty
    property p_hi_zero; wb_ack_o |-> wb_dat_o[31:8] == 24'h00_0000; endproperty
    property p_baud_rsvd;
        wb_ack_o && !wb_we_i && wb_adr_i[7:2] == 6'h02 |-> wb_dat_o[7:0] == br;
    endproperty
    property p_rst_quiet; $fell(rst_i) |-> !irq_o && !sck_oe_o && ss_o; endproperty
    property p_miso_in; sck_oe_o |-> !miso_oe_o; endproperty
    property p_one_data; !(mosi_oe_o && miso_oe_o); endproperty
    property p_ss_master; ss_oe_o |-> sck_oe_o; endproperty
    property p_fault_drop; s_lost [*3] |-> ##[0:3] !sck_oe_o; endproperty
    property p_no_fault; sck_oe_o && !master_conflict_flag_en && !wb_cyc_i |=> sck_oe_o; endproperty
    property p_baud_abort;
        wr_ok && wb_adr_i[7:2] == 6'h02 && (wb_dat_i[7:0] & 8'h77) != br && sck_oe_o && !ss_o
            |-> ##[1:3] ss_o;
    endproperty
    a_ack_next: assert property (p_ack_next) else $error("late ack");
    a_ack_src: assert property (p_ack_src) else $error("ack without request");
    a_hi_zero: assert property (p_hi_zero) else $error("upper read bits set");
    a_baud_rsvd: assert property (p_baud_rsvd) else $error("baud readback wrong");
    a_rst_quiet: assert property (p_rst_quiet) else $error("busy after reset");
    a_miso_in: assert property (p_miso_in) else $error("master drives miso");
    a_one_data: assert property (p_one_data) else $error("both data pins driven");
    a_ss_master: assert property (p_ss_master) else $error("select driven as slave");
    a_fault_drop: assert property (p_fault_drop) else $error("fault kept master");
    a_no_fault: assert property (p_no_fault) else $error("master lost");
    a_baud_abort: assert property (p_baud_abort) else $error("baud change kept byte");
endmodule

bind spims_port spims_props props_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq_o(irq_o),
    .ss_i(ss_i), .ss_o(ss_o), .ss_oe_o(ss_oe_o), .sck_oe_o(sck_oe_o),
    .mosi_oe_o(mosi_oe_o), .miso_oe_o(miso_oe_o));

// ### verification/spims_peer.sv
// far-side serial peripheral answering a master in clock phase one
module spims_peer (
    input wire sel_n_i, // select, active low
    input wire sck_i, // serial clock
    input wire mosi_i, // data from master
    input wire [7:0] tx_i, // reply byte
    output wire miso_o, // data to master
    output reg [7:0] rx_o // shifted in
);
    timeunit 1ns;
    timeprecision 1ps;
    reg q = 1'b0;
    // a fresh select reloads the reply
    always @(negedge sel_n_i) rx_o <= tx_i;
    // leading edge launches, trailing edge samples
    always @(posedge sck_i) q <= rx_o[7];
    always @(negedge sck_i) rx_o <= {rx_o[6:0], mosi_i};
    // released line shows the inverse so a stale bit cannot pass
    assign miso_o = sel_n_i ? ~q : q;
endmodule

// ### verification/spims_port_tb.sv
// self-checking bench: registers, master rates, abort, fault, slave in wait
module spims_port_tb;
    timeunit 1ns;
    timeprecision 1ps;
    reg clk_i = 1'b0;
    reg rst_i = 1'b1;
    reg cyc = 1'b0, stb = 1'b0, we = 1'b0, wt = 1'b0, sp = 1'b0;
    reg tss = 1'b1, tsck = 1'b0, tmosi = 1'b0;
    reg [3:0] sel = 4'h1;
    reg [7:0] adr = 8'h00, ptx = 8'h00, q;
    reg [31:0] dat = 32'h0000_0000;
    wire [31:0] dato;
    wire [7:0] prx;
    wire ack, irq, sso, ssoe, scko, sckoe, mosio, mosioe, misoo, misooe, pmiso;
    // pin levels from whoever drives each line
    wire ss = ssoe ? sso : tss;
    wire sck = sckoe ? scko : tsck;
    wire mosi = mosioe ? mosio : tmosi;
    wire miso = misooe ? misoo : pmiso;
    integer mismatches = 0, n_checks = 0;
    always #5 clk_i = ~clk_i;
    spims_port dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dato),
        .wb_ack_o(ack), .wait_i(wt), .stop_i(sp), .irq_o(irq), .ss_i(ss), .ss_o(sso),
        .ss_oe_o(ssoe), .sck_i(sck), .sck_o(scko), .sck_oe_o(sckoe), .mosi_i(mosi),
        .mosi_o(mosio), .mosi_oe_o(mosioe), .miso_i(miso), .miso_o(misoo),
        .miso_oe_o(misooe));
    spims_peer peer_u (.sel_n_i(ss), .sck_i(sck), .mosi_i(mosi), .tx_i(ptx),
        .miso_o(pmiso), .rx_o(prx));
    task chk(input string nm, input [31:0] e, input [31:0] g);
        n_checks++;
        if (g !== e) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    // one classic cycle, held until ack is sampled
    task wb(input w, input [7:0] a, input [7:0] d);
        integer n;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= {24'h00_0000, d};
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 20);
        if (ack !== 1'b1) chk("ack", 1, 0);
        q = dato[7:0];
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task rd(input [7:0] a, input [7:0] e, input string nm);
        wb(1'b0, a, 8'h00);
        chk(nm, e, q);
    endtask
    task sck_edge(output integer c);
        reg s;
        s = scko;
        c = 0;
        while (scko === s && c < 3000) begin
            @(posedge clk_i);
            c++;
        end
    endtask
    task t_reset;
        rd(8'h00, 8'h04, "ctl1");
        rd(8'h04, 8'h00, "ctl2");
        rd(8'h08, 8'h00, "baud");
        rd(8'h0c, 8'h20, "status");
        rd(8'h14, 8'h00, "data");
        rd(8'h3c, 8'h00, "unmapped");
        chk("irq off", 0, irq);
        wb(1'b1, 8'h00, 8'h44);
        @(posedge clk_i);
        chk("irq on", 1, irq);
        wb(1'b1, 8'h00, 8'h04);
        @(posedge clk_i);
        chk("irq off again", 0, irq);
        wb(1'b1, 8'h08, 8'hff);
        rd(8'h08, 8'h77, "baud rsvd");
        sel <= 4'h0;
        wb(1'b1, 8'h08, 8'h00);
        sel <= 4'h1;
        rd(8'h08, 8'h77, "baud lane");
        $display("test reset done");
    endtask
    // divisor is twice the half period measured between sck edges
    task t_master(input [7:0] br, input [7:0] tx, input [7:0] px);
        integer c, h;
        h = (br[6:4] + 1) << br[2:0];
        ptx <= px;
        wb(1'b1, 8'h08, br);
        tss <= 1'b0;
        wb(1'b1, 8'h00, 8'h54);
        wb(1'b1, 8'h14, tx);
        sck_edge(c);
        sck_edge(c);
        chk("half period", h, c);
        sp <= 1'b1;
        @(posedge clk_i);
        c = scko;
        repeat (300) @(posedge clk_i);
        chk("stop freeze", c, scko);
        sp <= 1'b0;
        c = 0;
        do begin
            wb(1'b0, 8'h0c, 8'h00);
            c++;
        end while (q[7] !== 1'b1 && c < 2000);
        rd(8'h14, px, "master rx");
        chk("peer rx", tx, prx);
        rd(8'h00, 8'h54, "ss ignored");
        rd(8'h0c, 8'h20, "no fault");
        tss <= 1'b1;
        wb(1'b1, 8'h00, 8'h04);
        $display("test master %h done", br);
    endtask
    task t_abort;
        integer c;
        wb(1'b1, 8'h08, 8'h07);
        wb(1'b1, 8'h00, 8'h54);
        wb(1'b1, 8'h14, 8'h5a);
        sck_edge(c);
        wb(1'b1, 8'h08, 8'h06);
        repeat (3000) @(posedge clk_i);
        rd(8'h0c, 8'h20, "abort status");
        chk("abort ss", 1, sso);
        wb(1'b1, 8'h00, 8'h04);
        $display("test abort done");
    endtask
    task t_fault;
        wb(1'b1, 8'h04, 8'h10);
        wb(1'b1, 8'h00, 8'h54);
        tss <= 1'b0;
        repeat (6) @(posedge clk_i);
        rd(8'h0c, 8'h30, "fault flag");
        rd(8'h00, 8'h44, "master cleared");
        chk("fault irq", 1, irq);
        tss <= 1'b1;
        repeat (4) @(posedge clk_i);
        rd(8'h0c, 8'h30, "fault held");
        wb(1'b1, 8'h0c, 8'h10);
        rd(8'h0c, 8'h20, "fault cleared");
        wb(1'b1, 8'h04, 8'h00);
        $display("test fault done");
    endtask
    // bench plays master; wait enters mid-byte so delivery waits for exit
    task t_slave;
        integer i;
        reg [7:0] m;
        wb(1'b1, 8'h04, 8'h02);
        wb(1'b1, 8'h00, 8'h44);
        wb(1'b1, 8'h14, 8'h3c);
        wt <= 1'b1;
        repeat (10) @(posedge clk_i);
        wt <= 1'b0;
        rd(8'h0c, 8'h20, "idle wait");
        tss <= 1'b0;
        for (i = 7; i >= 0; i--) begin
            repeat (8) @(posedge clk_i);
            tsck <= 1'b1;
            tmosi <= i[0] ^ (i > 3);
            if (i == 3) wt <= 1'b1;
            repeat (8) @(posedge clk_i);
            tsck <= 1'b0;
            m = {m[6:0], miso};
        end
        repeat (16) @(posedge clk_i);
        rd(8'h0c, 8'h20, "deferred");
        wt <= 1'b0;
        repeat (6) @(posedge clk_i);
        rd(8'h0c, 8'ha0, "delivered");
        rd(8'h14, 8'h5a, "slave rx");
        chk("slave tx", 8'h3c, m);
        tss <= 1'b1;
        $display("test slave done");
    endtask
    task stop_test;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // watchdog well past the longest run of all tests
    initial begin
        #300_000;
        mismatches++;
        $display("MISMATCH watchdog expected done seen timeout");
        stop_test;
    end
    initial begin
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset;
        t_master(8'h00, 8'h96, 8'h3b);
        t_master(8'h10, 8'h81, 8'hc4);
        t_master(8'h72, 8'h0f, 8'h70);
        t_master(8'h07, 8'h5a, 8'ha6);
        t_abort;
        t_fault;
        t_slave;
        stop_test;
    end
endmodule
